/* File: cmpc_top.v */
// comparator control, event and interrupt logic with its register file
`include "cmpc_regs.vh"

module cmpc_top (
    // clock and reset
    input  wire       core_clk,
    input  wire       nrst,
    // register port
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // analog comparator
    input  wire       cmp_out_async,
    output wire       comparator_power_down,
    output wire [1:0] reference_source_select,
    output wire [4:0] reference_level,
    // outputs to the rest of the chip
    output wire       port_a_pin2,
    output wire       timer_gate,
    output wire       irq
);

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg  [7:0] ctrl_r;
    reg        pol_r;
    reg        trig_r;
    reg  [4:0] level_r;
    reg  [2:0] stat_r;
    reg  [2:0] mask_r;
    reg        res_q_r;
    reg        res_valid_r;
    reg  [7:0] rdata_nxt;

    wire cmp_sync;
    wire pd;
    wire result;
    wire rise;
    wire fall;
    wire trig_evt;
    wire wr_ctrl;
    wire wr_flags;
    wire wr_level;
    wire wr_mask;
    wire rd_stat;
    wire clr_trig;
    wire [2:0] evt_vec;

    assign pd       = ctrl_r[`CMPC_CTRL_PD];
    assign wr_ctrl  = reg_wr && (reg_addr == `CMPC_ADDR_CTRL);
    assign wr_flags = reg_wr && (reg_addr == `CMPC_ADDR_FLAGS);
    assign wr_level = reg_wr && (reg_addr == `CMPC_ADDR_LEVEL);
    assign wr_mask  = reg_wr && (reg_addr == `CMPC_ADDR_IRQ_MASK);
    assign rd_stat  = reg_rd && (reg_addr == `CMPC_ADDR_IRQ_STAT);

    // ----------------------------------------
    // analog side
    // ----------------------------------------
    // comparator enabled by the inverse of this
    assign comparator_power_down   = pd;
    assign reference_source_select = ctrl_r[`CMPC_CTRL_SRC_HI:`CMPC_CTRL_SRC_LO];
    assign reference_level         = level_r;

    cmpc_sync u_sync (
        .core_clk (core_clk),
        .nrst     (nrst),
        .d_in     (cmp_out_async),
        .q_out    (cmp_sync)
    );

    // ----------------------------------------
    // result and edges
    // ----------------------------------------
    // invert, forced low in power-down
    assign result = !pd && (cmp_sync ^ ctrl_r[`CMPC_CTRL_INV]);

    // edge history is voided across power-down so waking does not fake an edge
    always @(posedge core_clk) begin
        if (!nrst) begin
            res_q_r     <= 1'b0;
            res_valid_r <= 1'b0;
        end else begin
            res_q_r     <= result;
            res_valid_r <= !pd;
        end
    end

    assign rise = res_valid_r && !pd && result && !res_q_r;
    assign fall = res_valid_r && !pd && !result && res_q_r;
    assign trig_evt = pol_r ? fall : rise;

    // ----------------------------------------
    // register writes and flags
    // ----------------------------------------
    // a written one clears, zero does nothing
    assign clr_trig = wr_flags && reg_wdata[`CMPC_FLG_CLR];

    always @(posedge core_clk) begin
        if (!nrst) begin
            ctrl_r  <= `CMPC_CTRL_RESET;
            pol_r   <= 1'b0;
            level_r <= 5'h00;
            mask_r  <= 3'h0;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= {reg_wdata[7:3], 3'h0};
            end
            if (wr_flags) begin
                pol_r <= reg_wdata[`CMPC_FLG_POL];
            end
            if (wr_level) begin
                level_r <= reg_wdata[4:0];
            end
            if (wr_mask) begin
                mask_r <= reg_wdata[2:0];
            end
        end
    end

    // set on trigger; set wins over clear
    always @(posedge core_clk) begin
        if (!nrst) begin
            trig_r <= 1'b0;
        end else if (trig_evt) begin
            trig_r <= 1'b1;
        end else if (clr_trig) begin
            trig_r <= 1'b0;
        end
    end

    // ----------------------------------------
    // interrupt status, cleared by reading it
    // ----------------------------------------
    assign evt_vec = {fall, rise, trig_evt};

    // new events in the read cycle survive the clear
    always @(posedge core_clk) begin
        if (!nrst) begin
            stat_r <= 3'h0;
        end else if (rd_stat) begin
            stat_r <= evt_vec;
        end else begin
            stat_r <= stat_r | evt_vec;
        end
    end

    // trigger flag holds the request level
    // interrupt, event pin and gate outputs
    assign irq = trig_r || (|(stat_r[2:1] & mask_r[2:1]))
                 || (stat_r[`CMPC_IRQ_TRIG] && mask_r[`CMPC_IRQ_TRIG]);
    assign port_a_pin2 = trig_r;
    assign timer_gate  = ctrl_r[`CMPC_CTRL_TGATE] && result;

    // ----------------------------------------
    // read path
    // ----------------------------------------
    always @* begin
        rdata_nxt = 8'h00;
        if (reg_addr == `CMPC_ADDR_CTRL) begin
            rdata_nxt = ctrl_r;
        end else if (reg_addr == `CMPC_ADDR_FLAGS) begin
            // result on bit 7, clear bit reads zero
            rdata_nxt = {result, pol_r, trig_r, 5'h00};
        end else if (reg_addr == `CMPC_ADDR_LEVEL) begin
            rdata_nxt = {3'h0, level_r};
        end else if (reg_addr == `CMPC_ADDR_IRQ_STAT) begin
            rdata_nxt = {5'h00, stat_r};
        end else if (reg_addr == `CMPC_ADDR_IRQ_MASK) begin
            rdata_nxt = {5'h00, mask_r};
        end
    end

    always @(posedge core_clk) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rdata_nxt;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

/* File: cmpc_regs.vh */
// register offsets, field positions and reset values of the comparator control block
`ifndef CMPC_REGS_VH
`define CMPC_REGS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CMPC_ADDR_CTRL      8'hda
`define CMPC_ADDR_FLAGS     8'hdb
`define CMPC_ADDR_LEVEL     8'hdc
`define CMPC_ADDR_IRQ_STAT  8'hdd
`define CMPC_ADDR_IRQ_MASK  8'hde

// ----------------------------------------
// reset values
// ----------------------------------------
`define CMPC_CTRL_RESET     8'he0
`define CMPC_FLAGS_RESET    8'h00
`define CMPC_LEVEL_RESET    8'h00
`define CMPC_MASK_RESET     8'h00

// ----------------------------------------
// control register fields
// ----------------------------------------
`define CMPC_CTRL_PD        7
`define CMPC_CTRL_SRC_HI    6
`define CMPC_CTRL_SRC_LO    5
`define CMPC_CTRL_INV       4
`define CMPC_CTRL_TGATE     3

// ----------------------------------------
// flag register fields
// ----------------------------------------
`define CMPC_FLG_RESULT     7
`define CMPC_FLG_POL        6
`define CMPC_FLG_TRIG       5
`define CMPC_FLG_CLR        4

// ----------------------------------------
// interrupt status / mask fields
// ----------------------------------------
`define CMPC_IRQ_TRIG       0
`define CMPC_IRQ_RISE       1
`define CMPC_IRQ_FALL       2

// ----------------------------------------
// reference level width and source codes
// ----------------------------------------
`define CMPC_LEVEL_W        5
`define CMPC_SRC_PIN1       2'h0
`define CMPC_SRC_BANDGAP    2'h1
`define CMPC_SRC_BG_SCALED  2'h2
`define CMPC_SRC_VDD_SCALED 2'h3

`endif

/* File: cmpc_sync.v */
// two-stage synchroniser for one asynchronous level
module cmpc_sync (
    // clock and reset
    input  wire core_clk,
    input  wire nrst,
    // level
    input  wire d_in,
    output wire q_out
);

    reg meta_r;
    reg sync_r;

    always @(posedge core_clk) begin
        if (!nrst) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
        end else begin
            meta_r <= d_in;
            sync_r <= meta_r;
        end
    end

    assign q_out = sync_r;

endmodule

/* File: cmpc_checker.sv */
// port checks for the comparator control block
module cmpc_checker (
    input logic       core_clk,
    input logic       nrst,
    input logic [7:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic       reg_wr,
    input logic       reg_rd,
    input logic [7:0] reg_rdata,
    input logic       comparator_power_down,
    input logic [1:0] reference_source_select,
    input logic [4:0] reference_level,
    input logic       port_a_pin2,
    input logic       timer_gate,
    input logic       irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);
    wire c_wr = reg_wr && reg_addr == 8'hda;
    wire f_wr = reg_wr && reg_addr == 8'hdb;
    pd_write_a:
        assert property (c_wr |=> comparator_power_down == $past(reg_wdata[7]))
        else $error("power down bit wrong");
    src_write_a:
        assert property (c_wr |=> reference_source_select == $past(reg_wdata[6:5]))
        else $error("source select wrong");
    level_write_a:
        assert property (reg_wr && reg_addr == 8'hdc |=> reference_level == $past(reg_wdata[4:0]))
        else $error("reference level wrong");
    flag_read_a:
        assert property (reg_rd && reg_addr == 8'hdb |=> reg_rdata[4:0] == 5'h00)
        else $error("clear bit or reserved bits read back");
    gate_off_a:
        assert property (comparator_power_down [*3] |-> !timer_gate)
        else $error("timer gate while powered down");
    irq_hold_a:
        assert property (port_a_pin2 |-> irq) else $error("irq low with flag set");
    flag_sticky_a:
        assert property (port_a_pin2 && !(f_wr && reg_wdata[4]) |=> port_a_pin2)
        else $error("trigger flag lost");
    trig_off_a:
        assert property ($rose(port_a_pin2) |-> !$past(comparator_power_down))
        else $error("trigger while powered down");
endmodule

bind cmpc_top cmpc_checker cmpc_checker_inst (.*);

/* File: cmpc_analog_model.sv */
// behavioural analog comparator with reference ladder
module cmpc_analog_model #(
    parameter int VDD_MV = 3300,
    parameter int BG_MV  = 1230
) (
    input  logic       comparator_power_down,
    input  logic [1:0] reference_source_select,
    input  logic [4:0] reference_level,
    input  int         pos_mv,
    input  int         pin1_mv,
    output logic       cmp_out_async
);
    timeunit 1ns;
    timeprecision 1ps;
    int neg_mv;
    always_comb begin
        case (reference_source_select)
            2'h0: neg_mv = pin1_mv;
            2'h1: neg_mv = BG_MV;
            2'h2: neg_mv = reference_level * BG_MV / 32;
            default: neg_mv = reference_level * VDD_MV / 32;
        endcase
    end
    assign cmp_out_async = comparator_power_down ? 1'b1 : pos_mv > neg_mv;
endmodule

/* File: tb_top.sv */
// self-checking bench for the comparator control block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, d;
    logic cmp_out_async, comparator_power_down, port_a_pin2, timer_gate, irq;
    logic [1:0] reference_source_select;
    logic [4:0] reference_level;
    int pos_mv = 0, pin1_mv = 500, n_errors = 0, n_tests = 0;
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
    $display("BAD %0t got %h exp %h", $time, a, b); end end
    cmpc_top cmpc_top_inst (.*);
    cmpc_analog_model cmpc_analog_model_inst (.*);
    initial forever #5 core_clk = ~core_clk;
    // ----------------------------------------
    // bus and stimulus helpers
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_wr <= 1; reg_addr <= a; reg_wdata <= v;
        @(posedge core_clk);
        reg_wr <= 0;
        // step off the write edge so callers see the settled registers
        #1;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        reg_rd <= 1; reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 0;
        #1 d = reg_rdata;
    endtask
    // input change then enough edges for sync and edge detect
    task automatic setv(input int mv);
        @(posedge core_clk);
        pos_mv <= mv;
        repeat (4) @(posedge core_clk);
        #1;
    endtask
    task automatic t_pd();
        rd(8'hda); `CHK(d, 8'he0)
        `CHK(comparator_power_down, 1'b1)
        `CHK(irq, 1'b0)
        wr(8'hda, 8'he8); setv(4000); rd(8'hdb);
        `CHK(d[7], 1'b0)
        `CHK(timer_gate, 1'b0)
    endtask
    task automatic t_regs();
        rd(8'hda); `CHK(d, 8'he8)
        wr(8'hdc, 8'hff); rd(8'hdc); `CHK(d, 8'h1f)
        wr(8'hda, 8'hff); rd(8'hda); `CHK(d, 8'hf8)
        wr(8'hd9, 8'hff); rd(8'hd9); `CHK(d, 8'h00)
    endtask
    task automatic t_src();
        wr(8'hdc, 8'h10); setv(1000);
        for (int s = 0; s < 4; s++) begin
            for (int v = 0; v < 2; v++) begin
                wr(8'hda, {1'b0, s[1:0], v[0], 4'h8}); setv(1000); rd(8'hdb);
                `CHK(d[7], (s == 0 || s == 2) ^ v[0])
                `CHK(timer_gate, (s == 0 || s == 2) ^ v[0])
                `CHK(reference_source_select, s[1:0])
            end
        end
        `CHK(reference_level, 5'h10)
        wr(8'hda, 8'h00); setv(1000);
        `CHK(timer_gate, 1'b0)
    endtask
    task automatic t_event();
        setv(0); wr(8'hdb, 8'h10); setv(1000);
        `CHK(port_a_pin2, 1'b1)
        `CHK(irq, 1'b1)
        wr(8'hdb, 8'h00); `CHK(port_a_pin2, 1'b1)
        wr(8'hdb, 8'h50); `CHK(port_a_pin2, 1'b0)
        setv(0); `CHK(port_a_pin2, 1'b1)
        wr(8'hdb, 8'h50); setv(1000); `CHK(port_a_pin2, 1'b0)
    endtask
    task automatic t_irq();
        wr(8'hde, 8'h07); rd(8'hde); `CHK(d, 8'h07)
        wr(8'hdb, 8'h10); rd(8'hdd); setv(0);
        `CHK(irq, 1'b1)
        rd(8'hdd); `CHK(d, 8'h04)
        `CHK(irq, 1'b0)
        wr(8'hde, 8'h00); setv(1000); wr(8'hdb, 8'h10);
        `CHK(irq, 1'b0)
        rd(8'hdd); `CHK(d, 8'h03)
    endtask
    task automatic final_report();
        if (n_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #200us;
        n_errors++;
        final_report();
    end
    initial begin
        repeat (6) @(posedge core_clk);
        nrst <= 1;
        t_pd(); t_regs(); t_src(); t_event(); t_irq();
        final_report();
    end
endmodule
